/* File: wfcb_defs.svh */
// Constants for the waveform capture buffer controller
`ifndef WFCB_DEFS_SVH
`define WFCB_DEFS_SVH
`define WFCB_BASE_ADDR     12'h800
`define WFCB_LAST_ADDR     12'hFFF
`define WFCB_SET_WORDS     8
`define WFCB_PAGE_WORDS    128
`define WFCB_NUM_PAGES     16
`define WFCB_NUM_SETS      256
`define WFCB_CENTER_WORDS  11'h400
`define WFCB_SRC_SINC      2'h0
`define WFCB_SRC_LPF       2'h2
`define WFCB_SRC_PCF       2'h3
`define WFCB_SHIFT         4
`define WFCB_IN_SLOT       3'h6
`define WFCB_SPARE_SLOT    3'h7
`define WFCB_TRIG_BITS     8
`endif

/* File: wfcb_pkg.sv */
// Types for the waveform capture buffer controller
package wfcb_pkg;
  typedef enum logic [1:0] {
    WFCB_FILL_STOP_FULL,
    WFCB_FILL_STOP_TRIG,
    WFCB_FILL_CENTER,
    WFCB_FILL_SAVE_ADDR
  } wfcb_mode_e;
  typedef enum logic [1:0] {
    WFCB_IDLE,
    WFCB_FILL,
    WFCB_POST,
    WFCB_DONE
  } wfcb_state_e;
endpackage

/* File: wfcb_sample_fmt.sv */
// Sample source select and word formatting for one channel
`timescale 1ns/10ps
`include "wfcb_defs.svh"
module wfcb_sample_fmt (
  // Selection
  input  wire logic [1:0]  i_src,
  // Candidate samples
  input  wire logic [23:0] i_sinc,
  input  wire logic [23:0] i_lpf,
  input  wire logic [31:0] i_pcf,
  // Formatted word
  output logic      [31:0] o_word
);
  // Shift left by four and sign extend sinc and LPF outputs; PCF passes unchanged
  always_comb begin
    unique case (i_src)
      `WFCB_SRC_LPF: o_word = {{4{i_lpf[23]}}, i_lpf, 4'h0};
      `WFCB_SRC_PCF: o_word = i_pcf;
      default:       o_word = {{4{i_sinc[23]}}, i_sinc, 4'h0};
    endcase
  end
endmodule

/* File: wfcb_capture.sv */
// Fixed-rate waveform capture buffer controller with its own memory
`timescale 1ns/10ps
`include "wfcb_defs.svh"
module wfcb_capture
  import wfcb_pkg::*;
#(
  parameter int NUM_CH   = 7,
  parameter int AW       = 11,
  parameter int NUM_PAGE = 16
) (
  // Clock and reset
  input  wire logic                     i_clock,
  input  wire logic                     i_rst,
  // Configuration
  input  wire logic                     i_capture_enable_bit,
  input  wire logic                     i_capture_select,
  input  wire logic [1:0]               i_fill_mode_field,
  input  wire logic [1:0]               i_sample_source_select,
  input  wire logic                     i_seventh_channel_store_enable,
  input  wire logic [NUM_PAGE-1:0]      i_page_indication_enable,
  input  wire logic [`WFCB_TRIG_BITS-1:0] i_trigger_config_register,
  input  wire logic                     i_page_full_irq_enable,
  input  wire logic                     i_trigger_stop_irq_enable,
  // Status clear pulses from host
  input  wire logic                     i_page_full_clear,
  input  wire logic                     i_trigger_stop_clear,
  // Trigger events, one bit per source
  input  wire logic [`WFCB_TRIG_BITS-1:0] i_trigger_events,
  // Sample streams; strobe marks a new simultaneous set
  input  wire logic                     i_sinc_strobe,
  input  wire logic                     i_slow_strobe,
  input  wire logic [NUM_CH*24-1:0]     i_sinc_data,
  input  wire logic [NUM_CH*24-1:0]     i_lpf_data,
  input  wire logic [NUM_CH*32-1:0]     i_processed_wave,
  // Host read port
  input  wire logic [AW-1:0]            i_read_addr,
  output logic      [31:0]              o_read_data,
  // Status
  output logic                          o_page_full_flag,
  output logic                          o_trigger_stop_flag,
  output logic                          o_trigger_seen_flag,
  output logic      [3:0]               o_last_completed_page,
  output logic      [11:0]              o_trigger_address_field,
  output logic                          o_filling,
  output logic                          o_first_interrupt_output
);

  // Word count of the buffer memory
  localparam int NUM_WORDS = 1 << AW;

  // Module state
  typedef struct packed {
    wfcb_state_e       state;
    logic [AW-1:0]     waddr;
    logic [2:0]        slot;
    logic              busy;
    logic [10:0]       post_cnt;
    logic              trig_done;
    logic              page_full;
    logic              trig_stop;
    logic              trig_seen;
    logic [3:0]        last_page;
    logic [11:0]       trig_addr;
    logic              en_prev;
    logic              irq;
    logic [31:0]       rdata;
    logic              filling;
  } wfcb_state_s;

  wfcb_state_s s_q, s_d;

  // Buffer memory and latched sample set
  logic [31:0]          mem [NUM_WORDS];
  logic [NUM_CH*32-1:0] set_words;
  logic [NUM_CH*32-1:0] set_q;
  logic [31:0]          wr_word;
  logic                 wr_en;

  // Formatters, one per channel
  // Source select shared by all channels
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_fmt
      wfcb_sample_fmt u_fmt (
        .i_src  (i_sample_source_select),
        .i_sinc (i_sinc_data[g*24 +: 24]),
        .i_lpf  (i_lpf_data[g*24 +: 24]),
        .i_pcf  (i_processed_wave[g*32 +: 32]),
        .o_word (set_words[g*32 +: 32])
      );
    end
  endgenerate

  // Map word address to its page number
  function automatic logic [3:0] page_of(input logic [AW-1:0] a);
    page_of = a[AW-1 -: 4];
  endfunction

  // Word selected for the current slot
  function automatic logic [31:0] slot_word(input logic [NUM_CH*32-1:0] w,
                                            input logic [2:0] sl);
    slot_word = w[sl*32 +: 32];
  endfunction

  // Decoded strobes and conditions
  logic set_strobe;
  logic trig_hit;
  logic start;
  logic last_word;
  logic page_end;

  // Next-state logic
  always_comb begin
    s_d        = s_q;
    // Strobe of the selected source, enabled triggers, address decode
    set_strobe = (i_sample_source_select == `WFCB_SRC_SINC) ? i_sinc_strobe
                                                            : i_slow_strobe;
    trig_hit   = |(i_trigger_events & i_trigger_config_register);
    start      = i_capture_enable_bit && !s_q.en_prev && i_capture_select;
    last_word  = (s_q.waddr == AW'(NUM_WORDS - 1));
    page_end   = (s_q.waddr[6:0] == 7'h7F);
    // Write port idle unless a slot is due
    wr_en      = 1'b0;
    wr_word    = 32'h0;
    s_d.en_prev = i_capture_enable_bit;

    // Host clears; hardware set below wins
    if (i_page_full_clear) begin
      s_d.page_full = 1'b0;
    end
    if (i_trigger_stop_clear) begin
      s_d.trig_stop = 1'b0;
    end

    // Disable stops writes at once; memory untouched
    if (!i_capture_enable_bit) begin
      s_d.state     = WFCB_IDLE;
      s_d.busy      = 1'b0;
      s_d.last_page = 4'h0;
      s_d.trig_addr = 12'h0;
      s_d.trig_seen = 1'b0;
      s_d.trig_done = 1'b0;
    end else if (start) begin
      // Fresh fill from the base address
      s_d.state     = WFCB_FILL;
      s_d.waddr     = '0;
      s_d.slot      = 3'h0;
      s_d.busy      = 1'b0;
      s_d.trig_done = 1'b0;
    end else if (s_q.state == WFCB_FILL || s_q.state == WFCB_POST) begin
      // Trigger handling while filling
      if (trig_hit && !s_q.trig_done && s_q.state == WFCB_FILL) begin
        unique case (wfcb_mode_e'(i_fill_mode_field))
          WFCB_FILL_STOP_TRIG: begin
            // Halt waits for the set boundary
            s_d.trig_done = 1'b1;
            s_d.trig_seen = 1'b1;
          end
          WFCB_FILL_CENTER: begin
            // Note address, then count the words after it
            s_d.trig_done = 1'b1;
            s_d.trig_seen = 1'b1;
            s_d.trig_addr = {1'b1, s_q.waddr};
            s_d.post_cnt  = `WFCB_CENTER_WORDS;
            s_d.state     = WFCB_POST;
          end
          WFCB_FILL_SAVE_ADDR: begin
            // First event only; filling goes on
            s_d.trig_done = 1'b1;
            s_d.trig_seen = 1'b1;
            s_d.trig_addr = {1'b1, s_q.waddr};
          end
          WFCB_FILL_STOP_FULL: begin
            // Triggers ignored in this mode
          end
        endcase
      end

      // Halt at a set boundary after stop-on-trigger
      if (s_q.trig_done && !s_q.busy &&
          wfcb_mode_e'(i_fill_mode_field) == WFCB_FILL_STOP_TRIG) begin
        s_d.state     = WFCB_DONE;
        s_d.trig_stop = 1'b1;
        s_d.trig_addr = {1'b1, s_q.waddr - AW'(2)};
      end else if (!s_q.busy && set_strobe) begin
        // Accept a set only between sets
        s_d.busy = 1'b1;
        s_d.slot = 3'h0;
      end else if (s_q.busy) begin
        // Write one word per cycle in fixed channel order
        wr_en = 1'b1;
        if (s_q.slot == `WFCB_SPARE_SLOT) begin
          wr_en = 1'b0;
        end else if (s_q.slot == `WFCB_IN_SLOT && !i_seventh_channel_store_enable) begin
          wr_en = 1'b0;
        end
        wr_word = slot_word(set_q, s_q.slot);
        s_d.slot  = s_q.slot + 3'h1;
        s_d.waddr = s_q.waddr + AW'(1);
        // Set done after its spare slot
        if (s_q.slot == `WFCB_SPARE_SLOT) begin
          s_d.busy = 1'b0;
        end

        // Page boundary: report page, raise enabled flag
        if (page_end) begin
          s_d.last_page = page_of(s_q.waddr);
          if (i_page_indication_enable[page_of(s_q.waddr)]) begin
            s_d.page_full = 1'b1;
          end
        end

        // Center mode: count the words after the trigger
        if (s_q.state == WFCB_POST) begin
          s_d.post_cnt = s_q.post_cnt - 11'h1;
          if (s_q.post_cnt == 11'h1) begin
            s_d.state     = WFCB_DONE;
            s_d.trig_stop = 1'b1;
            s_d.busy      = 1'b0;
          end
        end

        // Stop-when-full ends on the top word
        if (last_word && wfcb_mode_e'(i_fill_mode_field) == WFCB_FILL_STOP_FULL) begin
          s_d.state = WFCB_DONE;
          s_d.busy  = 1'b0;
        end
      end
    end

    // Masked interrupt, in step with the flags
    s_d.irq = (s_d.page_full && i_page_full_irq_enable) ||
              (s_d.trig_stop && i_trigger_stop_irq_enable);
    // Read port, one cycle of latency
    s_d.rdata = mem[i_read_addr];

    // Fill indication registered for the output
    s_d.filling = (s_d.state == WFCB_FILL) || (s_d.state == WFCB_POST);
  end

  // State register
  // Async reset clears every field
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '{state: WFCB_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Latch the simultaneous set at the strobe
  // No reset: data only, used under busy
  always_ff @(posedge i_clock) begin
    if (!s_q.busy && set_strobe) begin
      set_q <= set_words;
    end
  end

  // Buffer write port; contents kept when disabled
  // No reset: contents survive a disable
  always_ff @(posedge i_clock) begin
    if (wr_en) begin
      mem[s_q.waddr] <= wr_word;
    end
  end

  // Outputs from registers
  assign o_read_data              = s_q.rdata;
  assign o_page_full_flag         = s_q.page_full;
  assign o_trigger_stop_flag      = s_q.trig_stop;
  assign o_trigger_seen_flag      = s_q.trig_seen;
  assign o_last_completed_page    = s_q.last_page;
  assign o_trigger_address_field  = s_q.trig_addr;
  assign o_filling                = s_q.filling;
  assign o_first_interrupt_output = s_q.irq;
endmodule

/* File: wfcb_capture_properties.sv */
// Port checker for the waveform capture controller
`timescale 1ns/10ps
module wfcb_capture_properties (
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_rst,
  // Watched signals
  input wire logic        i_capture_enable_bit,
  input wire logic [1:0]  i_fill_mode_field,
  input wire logic        o_page_full_flag,
  input wire logic        o_trigger_stop_flag,
  input wire logic [3:0]  o_last_completed_page,
  input wire logic [11:0] o_trigger_address_field,
  input wire logic        o_filling,
  input wire logic        o_first_interrupt_output
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Interrupt needs a flag now or one cycle back
  property p_irq;
    !(o_page_full_flag | o_trigger_stop_flag | $past(o_page_full_flag)
      | $past(o_trigger_stop_flag)) |-> !o_first_interrupt_output;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without flag");
  // Enable low ends filling
  property p_stop; !i_capture_enable_bit |=> !o_filling; endproperty
  a_stop: assert property (p_stop) else $error("fill after disable");
  // Disable clears page and address
  property p_clr;
    !i_capture_enable_bit ##1 !i_capture_enable_bit
      |-> o_last_completed_page == 4'h0 && o_trigger_address_field == 12'h000;
  endproperty
  a_clr: assert property (p_clr) else $error("status kept");
  // Stop-when-full raises no stop flag
  property p_nofull; $rose(o_trigger_stop_flag) |-> $past(i_fill_mode_field) != 2'h0; endproperty
  a_nofull: assert property (p_nofull) else $error("stop flag in mode 0");
  // Recorded address lies in the buffer
  property p_addr; o_trigger_address_field != 12'h000 |-> o_trigger_address_field[11]; endproperty
  a_addr: assert property (p_addr) else $error("bad trigger address");
  // Last page only steps forward
  property p_page;
    $changed(o_last_completed_page) && $past(i_capture_enable_bit)
      |-> o_last_completed_page == $past(o_last_completed_page) + 4'h1;
  endproperty
  a_page: assert property (p_page) else $error("page jump");
  // Mode 0 ends only on page 15
  property p_full;
    $fell(o_filling) && i_capture_enable_bit && i_fill_mode_field == 2'h0
      |-> ##[0:2] o_last_completed_page == 4'hF;
  endproperty
  a_full: assert property (p_full) else $error("early stop");
  // Stop flag means filling halted
  property p_tstop; $rose(o_trigger_stop_flag) |-> ##[0:2] !o_filling; endproperty
  a_tstop: assert property (p_tstop) else $error("fill after stop");
  // Filling begins only when enabled
  property p_start; $rose(o_filling) |-> $past(i_capture_enable_bit); endproperty
  a_start: assert property (p_start) else $error("start unenabled");
endmodule
bind wfcb_capture wfcb_capture_properties u_chk (.i_clock, .i_rst, .i_capture_enable_bit,
  .i_fill_mode_field, .o_page_full_flag, .o_trigger_stop_flag, .o_last_completed_page,
  .o_trigger_address_field, .o_filling, .o_first_interrupt_output);

/* File: wfcb_host_model.sv */
// Host model: reads buffer words and restarts capture
`timescale 1ns/10ps
module wfcb_host_model (
  // Clock
  input  wire logic        i_clock,
  // Buffer side
  input  wire logic [31:0] i_read_data,
  input  wire logic [3:0]  i_last_page,
  output logic      [10:0] o_read_addr,
  output logic             o_capture_enable
);
  logic [3:0] seen_page;
  initial begin
    o_read_addr = 11'h000;
    o_capture_enable = 1'b0;
    seen_page = 4'h0;
  end
  // Word read, data one cycle after address
  task automatic rd(input logic [10:0] a, output logic [31:0] d);
    @(posedge i_clock) #1 o_read_addr = a;
    @(posedge i_clock) #1 d = i_read_data;
  endtask
  // Note newest page, then drop and raise enable
  task automatic restart();
    seen_page = i_last_page;
    @(posedge i_clock) #1 o_capture_enable = 1'b0;
    repeat (2) @(posedge i_clock);
    #1 o_capture_enable = 1'b1;
    repeat (2) @(posedge i_clock);
    #1;
  endtask
endmodule

/* File: wfcb_capture_tb_top.sv */
// Self-checking bench for the waveform capture controller
`timescale 1ns/10ps
module wfcb_capture_tb_top;
  logic         clk = 1'b0, rst = 1'b1, sel = 1'b1, ien = 1'b1, pirq = 1'b1;
  logic         tirq = 1'b1, pclr = 1'b0, tclr = 1'b0, stb = 1'b0, en;
  logic [1:0]   mode = 2'h0, src = 2'h0;
  logic [15:0]  pgen = 16'h8001;
  logic [7:0]   tcfg = 8'h02, tev = 8'h00;
  logic [167:0] sd = '0, ld = '0;
  logic [223:0] pd = '0;
  logic [10:0]  ra;
  logic [31:0]  rdat, w;
  logic [3:0]   lp;
  logic [11:0]  ta;
  logic         pf, ts, tsn, fil, irq;
  int           failures = 0, checks_done = 0;
  always #4 clk = ~clk;
  wfcb_capture u_dut (.i_clock(clk), .i_rst(rst), .i_capture_enable_bit(en),
    .i_capture_select(sel), .i_fill_mode_field(mode), .i_sample_source_select(src),
    .i_seventh_channel_store_enable(ien), .i_page_indication_enable(pgen),
    .i_trigger_config_register(tcfg), .i_page_full_irq_enable(pirq),
    .i_trigger_stop_irq_enable(tirq), .i_page_full_clear(pclr), .i_trigger_stop_clear(tclr),
    .i_trigger_events(tev), .i_sinc_strobe(stb), .i_slow_strobe(stb), .i_sinc_data(sd),
    .i_lpf_data(ld), .i_processed_wave(pd), .i_read_addr(ra), .o_read_data(rdat),
    .o_page_full_flag(pf), .o_trigger_stop_flag(ts), .o_trigger_seen_flag(tsn),
    .o_last_completed_page(lp), .o_trigger_address_field(ta), .o_filling(fil),
    .o_first_interrupt_output(irq));
  wfcb_host_model u_host (.i_clock(clk), .i_read_data(rdat), .i_last_page(lp),
    .o_read_addr(ra), .o_capture_enable(en));
  // Sample pattern per set, channel and source
  function automatic logic [23:0] smp(int n, int c, logic [7:0] k);
    return {n[7:0] ^ k, n[8], 3'h5, c[3:0], 8'h3C};
  endfunction
  function automatic logic [31:0] fx(logic [23:0] s);
    return {{4{s[23]}}, s, 4'h0};
  endfunction
  task automatic finish_test();
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rw(int a, logic [31:0] e);
    u_host.rd(a[10:0], w);
    chk("word", e, w);
  endtask
  // Send sets n.. with strobes 11 cycles apart
  task automatic put(int n, int cnt);
    for (int s = n; s < n + cnt; s++) begin
      for (int c = 0; c < 7; c++) begin
        sd[c*24 +: 24] = smp(s, c, 8'hA5);
        ld[c*24 +: 24] = smp(s, c, 8'h5A);
        pd[c*32 +: 32] = {smp(s, c, 8'hC3), 8'h77};
      end
      stb = 1'b1;
      @(posedge clk) #1 stb = 1'b0;
      repeat (10) @(posedge clk);
      #1;
    end
  endtask
  task automatic pulse_ev(logic [7:0] v);
    tev = v;
    @(posedge clk) #1 tev = 8'h00;
    @(posedge clk) #1;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    u_host.restart();
    put(0, 258);
    chk("filling", 0, fil);
    chk("last page", 15, lp);
    chk("page full", 1, pf);
    chk("irq", 1, irq);
    for (int c = 0; c < 7; c++) rw(c, fx(smp(0, c, 8'hA5)));
    rw(2043, fx(smp(255, 3, 8'hA5)));
    pclr = 1'b1;
    @(posedge clk) #1 pclr = 1'b0;
    mode = 2'h3;
    src = 2'h2;
    ien = 1'b0;
    pgen = 16'h0000;
    u_host.restart();
    chk("last page", 0, lp);
    chk("seen page", 15, u_host.seen_page);
    put(0, 3);
    pulse_ev(8'h02);
    chk("trig addr", 12'h818, ta);
    chk("trig seen", 1, tsn);
    put(3, 1);
    pulse_ev(8'h02);
    put(4, 254);
    chk("trig addr", 12'h818, ta);
    chk("filling", 1, fil);
    chk("page full", 0, pf);
    rw(0, fx(smp(256, 0, 8'h5A)));
    rw(6, fx(smp(0, 6, 8'hA5)));
    mode = 2'h1;
    src = 2'h3;
    tcfg = 8'h01;
    sel = 1'b0;
    u_host.restart();
    chk("filling", 0, fil);
    chk("trig seen", 0, tsn);
    sel = 1'b1;
    u_host.restart();
    chk("trig addr", 0, ta);
    put(0, 2);
    pulse_ev(8'h02);
    put(2, 1);
    chk("filling", 1, fil);
    pulse_ev(8'h01);
    put(3, 2);
    chk("filling", 0, fil);
    chk("stop flag", 1, ts);
    chk("irq", 1, irq);
    chk("trig addr", 12'h816, ta);
    rw(19, {smp(2, 3, 8'hC3), 8'h77});
    mode = 2'h2;
    src = 2'h0;
    tclr = 1'b1;
    @(posedge clk) #1 tclr = 1'b0;
    u_host.restart();
    chk("stop flag", 0, ts);
    put(0, 4);
    pulse_ev(8'h01);
    chk("trig addr", 12'h820, ta);
    put(4, 127);
    chk("filling", 1, fil);
    put(131, 3);
    chk("filling", 0, fil);
    chk("stop flag", 1, ts);
    finish_test();
  end
endmodule
